// [core/nvsc_params.svh]
// Timing counts and pin constants for the nonvolatile SRAM host controller.
// Assumes a 125 MHz clock; included by the package user modules by bare name.
`ifndef NVSC_PARAMS_SVH
`define NVSC_PARAMS_SVH
`define NVSC_CLK_MHZ 125
`define NVSC_ADDR_W 19
`define NVSC_DATA_W 16
`define NVSC_CYCLE_NS 45
`define NVSC_CYCLE_CYC ((`NVSC_CYCLE_NS * `NVSC_CLK_MHZ + 999) / 1000)
`define NVSC_WPULSE_NS 30
`define NVSC_WPULSE_CYC ((`NVSC_WPULSE_NS * `NVSC_CLK_MHZ + 999) / 1000)
`define NVSC_RDACC_NS 45
`define NVSC_RDACC_CYC ((`NVSC_RDACC_NS * `NVSC_CLK_MHZ + 999) / 1000)
`define NVSC_HSBPW_NS 15
`define NVSC_HSBPW_CYC ((`NVSC_HSBPW_NS * `NVSC_CLK_MHZ + 999) / 1000)
`define NVSC_RESTORE_MS 20
`define NVSC_RESTORE_CYC (`NVSC_RESTORE_MS * `NVSC_CLK_MHZ * 1000)
`define NVSC_SAVE_MS 8
`define NVSC_SAVE_CYC (`NVSC_SAVE_MS * `NVSC_CLK_MHZ * 1000)
`define NVSC_SWRECALL_US 200
`define NVSC_SWRECALL_CYC (`NVSC_SWRECALL_US * `NVSC_CLK_MHZ)
`define NVSC_SEQ_US 100
`define NVSC_SEQ_CYC (`NVSC_SEQ_US * `NVSC_CLK_MHZ)
`define NVSC_SEQ_LEN 6
`define NVSC_SEQ_A0 19'h0e38
`define NVSC_SEQ_A1 19'h31c7
`define NVSC_SEQ_A2 19'h03e0
`define NVSC_SEQ_A3 19'h3c1f
`define NVSC_SEQ_A4 19'h303f
`define NVSC_SEQ_SAVE 19'h0fc0
`define NVSC_SEQ_RESTORE 19'h0c63
`endif

// [core/nvsc_pkg.sv]
// Types shared by the nonvolatile SRAM host controller.
// Assumes nvsc_params.svh for widths.
`include "nvsc_params.svh"
package nvsc_pkg;
  typedef enum logic [2:0] {
    NVSC_OP_READ = 3'b000,
    NVSC_OP_WRITE = 3'b001,
    NVSC_OP_HWSAVE = 3'b010,
    NVSC_OP_SWSAVE = 3'b011,
    NVSC_OP_SWRESTORE = 3'b100
  } nvsc_op_t;
  typedef struct packed {
    nvsc_op_t op;
    logic [`NVSC_ADDR_W-1:0] addr;
    logic [`NVSC_DATA_W-1:0] wdata;
    logic [1:0] byteEn;
  } nvsc_req_t;
  typedef struct packed {
    logic chipSel_n;
    logic writeStrobe_n;
    logic outGate_n;
    logic upper_byte_lane_n;
    logic lower_byte_lane_n;
    logic [`NVSC_ADDR_W-1:0] addr;
  } nvsc_pins_t;
endpackage : nvsc_pkg

// [core/nvsc_timer.sv]
// Down counter used for access phases and long save or restore waits.
// Assumes one clock and synchronous active high reset.
`timescale 1ns/100ps
module nvsc_timer #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [W-1:0] loadVal,
  output logic done
);
  if (W < 1) begin : gWidthCheck
    $error("W must be at least 1");
  end
  logic [W-1:0] cnt_ff;
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= '0;
    end else if (load) begin
      cnt_ff <= loadVal;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - W'(1);
    end
  end
  // Pure count state: the sequencer derives its load from done, so done must not depend on load
  assign done = (cnt_ff == '0);
endmodule : nvsc_timer

// [core/nvsc_host.sv]
// Host controller driving a nonvolatile SRAM through its asynchronous pins.
// Assumes the memory supply rises with rst release; memory pins are off chip.
// Functional notes
// - Write strobe stays high through every read, including command reads.
// - Hardware save line stays released high during all ordinary accesses.
// - Save line may glitch at power edges; host ignores it then.
// - Byte lanes apply only in 16-bit organization.
// - Command is six reads of fixed addresses, strobe high throughout.
// - Each command step is a read ended by chip select.
`timescale 1ns/100ps
`include "nvsc_params.svh"
module nvsc_host #(
  parameter int WIDE = 1,
  parameter int RESTORE_CYC = `NVSC_RESTORE_CYC,
  parameter int SAVE_CYC = `NVSC_SAVE_CYC,
  parameter int SWRECALL_CYC = `NVSC_SWRECALL_CYC,
  parameter int SEQ_CYC = `NVSC_SEQ_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reqValid,
  input nvsc_pkg::nvsc_req_t req,
  output logic reqReady,
  output logic rspValid,
  output logic [`NVSC_DATA_W-1:0] rspData,
  output nvsc_pkg::nvsc_pins_t pins,
  output logic [`NVSC_DATA_W-1:0] dataOut,
  output logic dataOe,
  input wire logic [`NVSC_DATA_W-1:0] dataIn,
  output logic saveLineOut,
  output logic saveLineOe,
  input wire logic hw_save_line_n
);
  import nvsc_pkg::*;

  typedef enum logic [2:0] {
    NVSC_S_BOOT = 3'b000,
    NVSC_S_IDLE = 3'b001,
    NVSC_S_READ = 3'b010,
    NVSC_S_WRITE = 3'b011,
    NVSC_S_GAP = 3'b100,
    NVSC_S_SAVEPULSE = 3'b101,
    NVSC_S_WAIT = 3'b110
  } nvsc_state_t;

  if (WIDE != 0 && WIDE != 1) begin : gWideCheck
    $error("WIDE must be 0 or 1");
  end
  if (RESTORE_CYC < 1 || SAVE_CYC < 1 || SWRECALL_CYC < 1 || SEQ_CYC < 1) begin : gCountCheck
    $error("counts must be positive");
  end

  localparam logic [31:0] CycCyc = 32'(`NVSC_CYCLE_CYC);
  localparam logic [31:0] WrCyc = 32'(`NVSC_WPULSE_CYC);
  localparam logic [31:0] RdCyc = 32'(`NVSC_RDACC_CYC);
  localparam logic [31:0] HsbCyc = 32'(`NVSC_HSBPW_CYC);

  nvsc_state_t state_ff;
  nvsc_req_t cur_ff;
  logic [2:0] step_ff;
  logic waitLoad;
  logic [31:0] waitVal;
  logic tDone;
  logic [2:0] saveSync_ff;
  logic saveSeen_ff;
  logic [31:0] bootCnt_ff;

  nvsc_timer #(.W(32)) uTimer (
    .clk(clk),
    .rst(rst),
    .load(waitLoad),
    .loadVal(waitVal),
    .done(tDone)
  );

  // Three-stage sampling of the shared save line
  always_ff @(posedge clk) begin
    if (rst) begin
      saveSync_ff <= 3'h7;
      saveSeen_ff <= 1'b1;
    end else begin
      saveSync_ff <= {saveSync_ff[1:0], hw_save_line_n};
      if (saveSync_ff[1] == saveSync_ff[2]) begin
        saveSeen_ff <= saveSync_ff[2];
      end
    end
  end

  // Address of the current command step
  function automatic logic [`NVSC_ADDR_W-1:0] seqAddr(input logic [2:0] s, input nvsc_op_t op);
    case (s)
      3'h0: seqAddr = `NVSC_SEQ_A0;
      3'h1: seqAddr = `NVSC_SEQ_A1;
      3'h2: seqAddr = `NVSC_SEQ_A2;
      3'h3: seqAddr = `NVSC_SEQ_A3;
      3'h4: seqAddr = `NVSC_SEQ_A4;
      default: seqAddr = (op == NVSC_OP_SWSAVE) ? `NVSC_SEQ_SAVE : `NVSC_SEQ_RESTORE;
    endcase
  endfunction : seqAddr

  logic isSeq;
  assign isSeq = (cur_ff.op == NVSC_OP_SWSAVE) || (cur_ff.op == NVSC_OP_SWRESTORE);

  always_comb begin
    waitLoad = 1'b0;
    waitVal = '0;
    case (state_ff)
      NVSC_S_BOOT: begin
        waitLoad = 1'b0;
      end
      NVSC_S_IDLE: begin
        if (reqValid) begin
          waitLoad = 1'b1;
          case (req.op)
            NVSC_OP_WRITE: waitVal = WrCyc;
            NVSC_OP_HWSAVE: waitVal = HsbCyc;
            default: waitVal = RdCyc;
          endcase
        end
      end
      NVSC_S_READ, NVSC_S_WRITE: begin
        if (tDone) begin
          waitLoad = 1'b1;
          waitVal = CycCyc;
        end
      end
      NVSC_S_GAP: begin
        if (tDone && isSeq && step_ff != 3'(`NVSC_SEQ_LEN - 1)) begin
          waitLoad = 1'b1;
          waitVal = RdCyc;
        end else if (tDone && isSeq) begin
          // Command time plus save or restore lockout
          waitLoad = 1'b1;
          waitVal = 32'(SEQ_CYC) + ((cur_ff.op == NVSC_OP_SWSAVE) ? 32'(SAVE_CYC) : 32'(SWRECALL_CYC));
        end
      end
      NVSC_S_SAVEPULSE: begin
        if (tDone) begin
          waitLoad = 1'b1;
          waitVal = 32'(SAVE_CYC);
        end
      end
      default: begin
        waitLoad = 1'b0;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= NVSC_S_BOOT;
      cur_ff <= '0;
      step_ff <= '0;
    end else begin
      case (state_ff)
        NVSC_S_BOOT: begin
          // Power-up restore window; save line glitches ignored
          if (bootCnt_ff == 32'(RESTORE_CYC)) begin
            state_ff <= NVSC_S_IDLE;
          end
        end
        NVSC_S_IDLE: begin
          if (reqValid) begin
            cur_ff <= req;
            step_ff <= '0;
            case (req.op)
              NVSC_OP_WRITE: state_ff <= NVSC_S_WRITE;
              NVSC_OP_HWSAVE: state_ff <= NVSC_S_SAVEPULSE;
              default: state_ff <= NVSC_S_READ;
            endcase
          end
        end
        NVSC_S_READ, NVSC_S_WRITE: begin
          if (tDone) begin
            state_ff <= NVSC_S_GAP;
          end
        end
        NVSC_S_GAP: begin
          if (tDone) begin
            if (isSeq && step_ff != 3'(`NVSC_SEQ_LEN - 1)) begin
              step_ff <= step_ff + 3'h1;
              state_ff <= NVSC_S_READ;
            end else if (isSeq) begin
              state_ff <= NVSC_S_WAIT;
            end else begin
              state_ff <= NVSC_S_IDLE;
            end
          end
        end
        NVSC_S_SAVEPULSE: begin
          if (tDone) begin
            state_ff <= NVSC_S_WAIT;
          end
        end
        NVSC_S_WAIT: begin
          // No traffic until the save or restore has surely ended
          if (tDone) begin
            state_ff <= NVSC_S_IDLE;
          end
        end
        default: begin
          state_ff <= NVSC_S_BOOT;
        end
      endcase
    end
  end

  // Power-up restore counter
  always_ff @(posedge clk) begin
    if (rst) begin
      bootCnt_ff <= '0;
    end else if (state_ff == NVSC_S_BOOT && bootCnt_ff != 32'(RESTORE_CYC)) begin
      bootCnt_ff <= bootCnt_ff + 32'h1;
    end
  end

  // Pin drive
  logic active;
  assign active = (state_ff == NVSC_S_READ) || (state_ff == NVSC_S_WRITE);
  always_ff @(posedge clk) begin
    if (rst) begin
      pins <= '{chipSel_n: 1'b1, writeStrobe_n: 1'b1, outGate_n: 1'b1, upper_byte_lane_n: 1'b1,
                lower_byte_lane_n: 1'b1, addr: '0};
      dataOut <= '0;
      dataOe <= 1'b0;
    end else begin
      pins.chipSel_n <= !active;
      // Strobe low only in write phase, never for reads
      pins.writeStrobe_n <= !(state_ff == NVSC_S_WRITE);
      // Gate held off in writes so the memory floats its outputs
      pins.outGate_n <= !(state_ff == NVSC_S_READ);
      // Lanes only meaningful in wide mode; held low otherwise
      pins.upper_byte_lane_n <= (WIDE != 0) ? !(active && (isSeq || cur_ff.byteEn[1])) : 1'b0;
      pins.lower_byte_lane_n <= (WIDE != 0) ? !(active && (isSeq || cur_ff.byteEn[0])) : 1'b0;
      pins.addr <= isSeq ? seqAddr(step_ff, cur_ff.op) : cur_ff.addr;
      dataOut <= cur_ff.wdata;
      dataOe <= (state_ff == NVSC_S_WRITE);
    end
  end

  // Save line: driven low only for a hardware save pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      saveLineOut <= 1'b1;
      saveLineOe <= 1'b0;
    end else begin
      saveLineOut <= 1'b0;
      saveLineOe <= (state_ff == NVSC_S_SAVEPULSE);
    end
  end

  // Answer path
  always_ff @(posedge clk) begin
    if (rst) begin
      reqReady <= 1'b0;
      rspValid <= 1'b0;
      rspData <= '0;
    end else begin
      reqReady <= (state_ff == NVSC_S_IDLE && !reqValid) || (state_ff == NVSC_S_GAP && tDone && !isSeq)
                  || (state_ff == NVSC_S_WAIT && tDone) || (state_ff == NVSC_S_BOOT
                  && bootCnt_ff == 32'(RESTORE_CYC));
      rspValid <= (state_ff == NVSC_S_READ && tDone && cur_ff.op == NVSC_OP_READ)
                  || (state_ff == NVSC_S_WRITE && tDone) || (state_ff == NVSC_S_WAIT && tDone);
      if (state_ff == NVSC_S_READ && tDone) begin
        rspData <= (WIDE != 0) ? dataIn : {8'h00, dataIn[7:0]};
      end
    end
  end
endmodule : nvsc_host

// [tb/nvsc_mem.sv]
// Behavioural nonvolatile SRAM on the controller's pins.
// Assumes pins are sampled on the host clock.
`timescale 1ns/100ps
`include "nvsc_params.svh"
module nvsc_mem #(
  parameter int BUSY = 16
) (
  input wire logic clk,
  input nvsc_pkg::nvsc_pins_t pins,
  input wire logic [`NVSC_DATA_W-1:0] dataOut,
  input wire logic saveLineOut,
  input wire logic saveLineOe,
  output logic [`NVSC_DATA_W-1:0] dataIn,
  output logic hw_save_line_n
);
  import nvsc_pkg::*;
  logic [15:0] mem [int];
  logic [15:0] nv [int];
  logic [18:0] seqA [5];
  nvsc_pins_t p;
  logic dirty = 1'b0;
  logic hiZ = 1'b0;
  int busy = BUSY;
  int seqN = 0;
  assign hw_save_line_n = saveLineOe ? saveLineOut : 1'b1;
  initial begin
    dataIn = '0;
    p = '1;
    seqA = '{`NVSC_SEQ_A0, `NVSC_SEQ_A1, `NVSC_SEQ_A2, `NVSC_SEQ_A3, `NVSC_SEQ_A4};
  end
  always @(posedge clk) begin
    logic [15:0] rd;
    int a;
    logic wrNow;
    a = int'(pins.addr);
    wrNow = !pins.chipSel_n && !pins.writeStrobe_n;
    rd = mem.exists(a) ? mem[a] : 16'h0000;
    p <= pins;
    dataIn <= ~dataIn;
    if (p.chipSel_n && !pins.chipSel_n) begin
      hiZ <= !pins.writeStrobe_n;
    end
    if (busy > 0) begin
      busy <= busy - 1;
    end else if (!hw_save_line_n) begin
      // A write already under way still lands before the image is taken
      if (wrNow) begin
        mem[a] = {pins.upper_byte_lane_n ? rd[15:8] : dataOut[15:8],
                  pins.lower_byte_lane_n ? rd[7:0] : dataOut[7:0]};
      end
      if (dirty || wrNow) begin
        nv = mem;
      end
      busy <= (dirty || wrNow) ? BUSY : 0;
      dirty <= 1'b0;
    end else if (!pins.chipSel_n && !pins.writeStrobe_n) begin
      mem[a] = {pins.upper_byte_lane_n ? rd[15:8] : dataOut[15:8],
                pins.lower_byte_lane_n ? rd[7:0] : dataOut[7:0]};
      dirty <= 1'b1;
    end else if (!pins.chipSel_n && !pins.outGate_n && !hiZ) begin
      dataIn <= {pins.upper_byte_lane_n ? ~dataIn[15:8] : rd[15:8],
                 pins.lower_byte_lane_n ? ~dataIn[7:0] : rd[7:0]};
    end
    if (busy == 0 && !p.chipSel_n && pins.chipSel_n && !p.outGate_n) begin
      if (seqN == 5 && (p.addr == `NVSC_SEQ_SAVE || p.addr == `NVSC_SEQ_RESTORE)) begin
        if (p.addr == `NVSC_SEQ_SAVE) begin
          nv = mem;
        end else begin
          mem = nv;
        end
        busy <= BUSY;
        dirty <= 1'b0;
        seqN <= 0;
      end else begin
        seqN <= (seqN < 5 && p.addr == seqA[seqN]) ? seqN + 1 : 0;
      end
    end
  end
endmodule : nvsc_mem

// [tb/nvsc_host_asserts.sv]
// Pin protocol checks for the nonvolatile SRAM host controller.
// Assumes binding into nvsc_host; one clock, sync reset.
`timescale 1ns/100ps
module nvsc_host_asserts #(
  parameter int WIDE = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reqValid,
  input nvsc_pkg::nvsc_req_t req,
  input wire logic reqReady,
  input nvsc_pkg::nvsc_pins_t pins,
  input wire logic dataOe,
  input wire logic saveLineOe
);
  import nvsc_pkg::*;
  logic [1:0] be_ff;
  always_ff @(posedge clk) begin
    if (reqValid && reqReady) begin
      be_ff <= req.byteEn;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  read_strobe_a: assert property (!pins.chipSel_n && !pins.outGate_n |-> pins.writeStrobe_n)
    else $error("strobe low in read");
  save_idle_a: assert property (saveLineOe |-> pins.chipSel_n && !dataOe)
    else $error("save during access");
  bus_dir_a: assert property (!pins.outGate_n |-> !dataOe)
    else $error("drive during read");
  boot_wait_a: assert property ($fell(rst) |-> !reqReady [*8])
    else $error("ready during restore");
  lane_sel_a: assert property (!pins.writeStrobe_n |->
    {pins.upper_byte_lane_n, pins.lower_byte_lane_n} == (WIDE == 1 ? ~be_ff : 2'b00))
    else $error("lane mismatch");
  read_len_a: assert property ($fell(pins.chipSel_n) && !pins.outGate_n |->
    (!pins.chipSel_n && pins.writeStrobe_n) [*6])
    else $error("short read");
  cs_gap_a: assert property ($rose(pins.chipSel_n) |-> pins.chipSel_n [*5])
    else $error("short gap");
  ready_idle_a: assert property (reqReady |-> pins.chipSel_n && !saveLineOe)
    else $error("busy while ready");
  cover property ($fell(pins.chipSel_n) && !pins.outGate_n);
  cover property ($fell(pins.writeStrobe_n));
  cover property ($rose(saveLineOe));
endmodule : nvsc_host_asserts
bind nvsc_host nvsc_host_asserts #(.WIDE(WIDE)) chk_i (.clk(clk), .rst(rst), .reqValid(reqValid),
  .req(req), .reqReady(reqReady), .pins(pins), .dataOe(dataOe), .saveLineOe(saveLineOe));

// [tb/nvsc_host_tb.sv]
// Self-checking bench for the nonvolatile SRAM host controller.
// Assumes nvsc_mem on the far side and shortened long counts.
`timescale 1ns/100ps
`include "nvsc_params.svh"
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module nvsc_host_tb;
  import nvsc_pkg::*;
  logic clk, rst, reqValid, reqReady, rspValid, dataOe, saveLineOut, saveLineOe, hw_save_line_n;
  nvsc_req_t req;
  nvsc_pins_t pins;
  logic [15:0] rspData, dataOut, dataIn;
  logic rdyS, rvS, csPrev, mon;
  int fails, nCompared, csFalls, weLow, hsbLow;
  nvsc_host #(.WIDE(1), .RESTORE_CYC(20), .SAVE_CYC(20), .SWRECALL_CYC(20), .SEQ_CYC(20)) nvsc_host_i (
    .clk(clk), .rst(rst), .reqValid(reqValid), .req(req), .reqReady(reqReady), .rspValid(rspValid),
    .rspData(rspData), .pins(pins), .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn),
    .saveLineOut(saveLineOut), .saveLineOe(saveLineOe), .hw_save_line_n(hw_save_line_n));
  nvsc_mem nvsc_mem_i (.clk(clk), .pins(pins), .dataOut(dataOut), .saveLineOut(saveLineOut),
    .saveLineOe(saveLineOe), .dataIn(dataIn), .hw_save_line_n(hw_save_line_n));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(negedge clk) begin
    rdyS <= reqReady;
    rvS <= rspValid;
    csPrev <= pins.chipSel_n;
    if (mon && csPrev && !pins.chipSel_n) csFalls++;
    if (mon && !pins.writeStrobe_n) weLow++;
    if (mon && !hw_save_line_n) hsbLow++;
  end
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic waitHi(ref logic s);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (s !== 1'b1 && k < 3000);
    if (s !== 1'b1) begin
      fails++;
      report_and_stop();
    end
  endtask : waitHi
  task automatic doReq(input nvsc_op_t op, input logic [18:0] a, input logic [15:0] d, input logic [1:0] be);
    reqValid <= 1'b1;
    req <= '{op: op, addr: a, wdata: d, byteEn: be};
    waitHi(rdyS);
    reqValid <= 1'b0;
    waitHi(rvS);
  endtask : doReq
  task automatic tRw();
    doReq(NVSC_OP_WRITE, 19'h0000a, 16'h5a3c, 2'b11);
    doReq(NVSC_OP_WRITE, 19'h3ffff, 16'hc3a5, 2'b11);
    doReq(NVSC_OP_READ, 19'h0000a, 16'h0000, 2'b11);
    `CHK(rspData, 16'h5a3c)
    doReq(NVSC_OP_READ, 19'h3ffff, 16'h0000, 2'b11);
    `CHK(rspData, 16'hc3a5)
    $display("test rw done");
  endtask : tRw
  task automatic tLanes();
    doReq(NVSC_OP_WRITE, 19'h00020, 16'hffff, 2'b11);
    doReq(NVSC_OP_WRITE, 19'h00020, 16'h1200, 2'b10);
    doReq(NVSC_OP_WRITE, 19'h00020, 16'h0034, 2'b01);
    doReq(NVSC_OP_READ, 19'h00020, 16'h0000, 2'b11);
    `CHK(rspData, 16'h1234)
    $display("test lanes done");
  endtask : tLanes
  task automatic tCmd();
    nvsc_op_t ops [2];
    ops = '{NVSC_OP_SWSAVE, NVSC_OP_SWRESTORE};
    doReq(NVSC_OP_WRITE, 19'h00040, 16'hbeef, 2'b11);
    foreach (ops[i]) begin
      csFalls = 0;
      weLow = 0;
      mon = 1'b1;
      doReq(ops[i], 19'h00000, 16'h0000, 2'b11);
      mon = 1'b0;
      `CHK(csFalls, 6)
      `CHK(weLow, 0)
      if (i == 0) doReq(NVSC_OP_WRITE, 19'h00040, 16'h0bad, 2'b11);
    end
    doReq(NVSC_OP_READ, 19'h00040, 16'h0000, 2'b11);
    `CHK(rspData, 16'hbeef)
    $display("test command done");
  endtask : tCmd
  task automatic tHwSave();
    doReq(NVSC_OP_WRITE, 19'h00060, 16'h7e81, 2'b11);
    csFalls = 0;
    hsbLow = 0;
    mon = 1'b1;
    doReq(NVSC_OP_HWSAVE, 19'h00000, 16'h0000, 2'b11);
    mon = 1'b0;
    `CHK(hsbLow > 0, 1'b1)
    `CHK(csFalls, 0)
    doReq(NVSC_OP_WRITE, 19'h00060, 16'h0000, 2'b11);
    doReq(NVSC_OP_SWRESTORE, 19'h00000, 16'h0000, 2'b11);
    doReq(NVSC_OP_READ, 19'h00060, 16'h0000, 2'b11);
    `CHK(rspData, 16'h7e81)
    $display("test hardware save done");
  endtask : tHwSave
  initial begin
    rst = 1'b1;
    reqValid = 1'b0;
    req = '0;
    mon = 1'b0;
    fails = 0;
    nCompared = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    tRw();
    tLanes();
    tCmd();
    tHwSave();
    report_and_stop();
  end
endmodule : nvsc_host_tb
